// >>> logic/sde_defines.svh
/*
 * Constants of the single-wire output encoder: register map, field
 * positions, reset values, SENT and PWM timing counts, special codes.
 * Assumes a 200 MHz system clock; included by bare name.
 */
`ifndef SDE_DEFINES_SVH
`define SDE_DEFINES_SVH

// ********************************************************************
// Clock and SENT timing
// ********************************************************************
`define SDE_CLK_MHZ        200
`define SDE_TICK_NS        3000
`define SDE_TICK_CYC       ((`SDE_TICK_NS * `SDE_CLK_MHZ) / 1000)
`define SDE_NLOW_TICKS     8'h05
`define SDE_SYNC_TICKS     8'h38
`define SDE_NIB_BASE       8'h0c
`define SDE_FRAME_TICKS    16'h0200
`define SDE_INIT_US        2000
`define SDE_INIT_CYC       (`SDE_INIT_US * `SDE_CLK_MHZ)

// ********************************************************************
// PWM timing (period counts in clock cycles)
// ********************************************************************
`define SDE_PWM_1K         32'd200000
`define SDE_PWM_500        32'd400000
`define SDE_PWM_200        32'd1000000
`define SDE_PWM_2K         32'd100000

// ********************************************************************
// Register map (byte addresses)
// ********************************************************************
`define SDE_REG_SETUP      4'h0
`define SDE_REG_VALUE      4'h4
`define SDE_REG_FAULT      4'h8
`define SDE_REG_STATUS     4'hc
`define SDE_SETUP_RESET    16'h0000

// ********************************************************************
// Setup fields
// ********************************************************************
`define SDE_B_LOCK         0
`define SDE_B_DIAGOFF      1
`define SDE_B_EBAND        7
`define SDE_B_FREQ_LO      10
`define SDE_B_FMT          12

// ********************************************************************
// Fault register bits
// ********************************************************************
`define SDE_F_SELFTEST     0
`define SDE_F_OVERV        1
`define SDE_F_UNDERV       2
`define SDE_F_FLDHI        3
`define SDE_F_FLDLO        4
`define SDE_F_ADDOVF       5
`define SDE_F_CLIP         6
`define SDE_F_CLAMPHI      7
`define SDE_F_CLAMPLO      8
`define SDE_F_INIT         9

// ********************************************************************
// Data codes and CRC
// ********************************************************************
`define SDE_CODE_INIT      12'h000
`define SDE_CODE_CLAMPLO   12'h001
`define SDE_CODE_CLAMPHI   12'hff8
`define SDE_CODE_PATH      12'hffa
`define SDE_CODE_DEVICE    12'hffb
`define SDE_POS_MIN        12'h002
`define SDE_POS_MAX        12'hff7
`define SDE_CRC_SEED       4'h5
`define SDE_CRC_POLY       4'hd

`endif

// >>> logic/sde_encoder.sv
/*
 * Output encoder: turns a 12-bit value and the fault state into a SENT
 * telegram, a fault-coded PWM wave, or an analog error-band decision.
 * Assumes synchronous inputs, one 200 MHz clock, Avalon-MM registers.
 */
// Decided for this implementation: the register offsets and the Avalon-MM register port.
//
// How it works
// R1: Telegram starts low; periods are falling-to-falling
// R2: Sync, status, three data, CRC, pause
// R3: All timing counted in whole ticks
// R4: Line idles high after reset; in the reset-default PWM mode the code holds it low during init
// R5: Every low pulse has fixed length
// R6: Fixed sync; nibble high grows with value
// R7: Pause pads telegram to fixed frame
// R8: CRC covers data nibbles only
// R9: Polynomial x4+x3+x2+1, seed five
// R10: Extra zero nibble fed to CRC
// R11: Data from 12-bit value, position 2..4087
// R12: Status nibble always zero
// R13: Self-test or overvoltage sends 4091
// R14: Field, adder or clip errors send 4090
// R15: Clamps send 4088 and 1 only
// R16: Code 0 during initialisation
// R17: No SENT before init time elapses
// R18: PWM fault halves frequency
// R19: Duty 95, 62.5, 55 percent by fault
// R20: Duty 75 overvoltage, 70 clipping
// R21: Undervoltage holds line per band bit; the code holds it in PWM mode only
// R22: Analog output goes to error band
// R23: Format bit 12: 0 PWM, 1 SENT
// R24: Locked: band bit 0 high, 1 low
// R25: Unlocked always uses high band
// R26: Diagnosis bit 1 set masks errors
// R27: Device error beats path and clamp
`include "sde_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sde_encoder
	import sde_pkg::*;
#(
	parameter int INIT_CYC = `SDE_INIT_CYC	// Power-up init time, cycles
) (
	input  wire logic        clock,            // System clock
	input  wire logic        rst_n,            // Sync reset, active low
	input  wire logic [3:0]  avs_address,      // Byte address
	input  wire logic        avs_read,         // Read request
	input  wire logic        avs_write,        // Write request
	input  wire logic [31:0] avs_writedata,    // Write data
	input  wire logic [3:0]  avs_byteenable,   // Byte lanes
	output logic      [31:0] avs_readdata,     // Read data
	output logic             avs_waitrequest,  // Stall
	output logic             lineOut,          // Output line level
	output logic             errorBand,        // Analog error band active
	output logic             errorBandLow      // Band is low side
);
	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [15:0] setup_r;      // Customer setup register
	logic [11:0] value_r;      // Output value
	logic [9:0]  fault_r;      // Fault inputs from software
	logic        ack_r;        // Bus answer phase
	logic [31:0] rdata_r;      // Read data
	logic [31:0] initCnt_r;    // Power-up timer
	logic        initDone_r;   // Init time elapsed

	// All storage is flip-flops
	// Fault bits set and cleared by software
	// Encoder only decodes them


	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire req     = avs_read | avs_write;
	wire wrTake  = avs_write & ack_r;
	wire selSet  = avs_address == `SDE_REG_SETUP;
	wire selVal  = avs_address == `SDE_REG_VALUE;
	wire selFlt  = avs_address == `SDE_REG_FAULT;
	wire selSta  = avs_address == `SDE_REG_STATUS;
	// One wait state on every access, then the answer
	assign avs_waitrequest = req & ~ack_r;
	assign avs_readdata    = rdata_r;

	// Exactly one wait state per access
	// Read data loaded in the wait state


	// Byte-lane merge used by every writable register
	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	wire [31:0] setupNxt = laneMerge({16'h0000, setup_r}, avs_writedata, avs_byteenable);
	wire [31:0] valueNxt = laneMerge({20'h00000, value_r}, avs_writedata, avs_byteenable);
	wire [31:0] faultNxt = laneMerge({22'h000000, fault_r}, avs_writedata, avs_byteenable);

	// ****************************************************************
	// Diagnostics and data code
	// ****************************************************************
	sde_fault_t flt;
	assign flt.selfTest = fault_r[`SDE_F_SELFTEST];
	assign flt.overV    = fault_r[`SDE_F_OVERV];
	assign flt.underV   = fault_r[`SDE_F_UNDERV];
	assign flt.fieldHi  = fault_r[`SDE_F_FLDHI];
	assign flt.fieldLo  = fault_r[`SDE_F_FLDLO];
	assign flt.pathErr  = fault_r[`SDE_F_ADDOVF] | fault_r[`SDE_F_CLIP];
	assign flt.clampHi  = fault_r[`SDE_F_CLAMPHI];
	assign flt.clampLo  = fault_r[`SDE_F_CLAMPLO];
	assign flt.init     = fault_r[`SDE_F_INIT] | ~initDone_r;

	wire diagOn  = ~setup_r[`SDE_B_DIAGOFF];                          // [R26]
	wire bandLow = setup_r[`SDE_B_LOCK] & setup_r[`SDE_B_EBAND];       // [R24] [R25]
	wire devErr  = diagOn & (flt.selfTest | flt.overV);
	wire pathEr  = diagOn & (flt.fieldHi | flt.fieldLo | flt.pathErr);
	wire anyErr  = devErr | pathEr | (diagOn & flt.underV);
	// Clamp position into the legal window so reserved codes never go out
	wire [11:0] posCode = (value_r < `SDE_POS_MIN) ? `SDE_POS_MIN :
		(value_r > `SDE_POS_MAX) ? `SDE_POS_MAX : value_r;  // [R11] [R15]
	// Priority: init, device, path, clamps, position
	wire [11:0] dataCode = flt.init ? `SDE_CODE_INIT :                 // [R16]
		devErr ? `SDE_CODE_DEVICE :                                       // [R13] [R27]
		pathEr ? `SDE_CODE_PATH :                                         // [R14]
		flt.clampHi ? `SDE_CODE_CLAMPHI :                                 // [R15]
		flt.clampLo ? `SDE_CODE_CLAMPLO : posCode;

	// Device error wins over path error
	// Clamps reported even with diagnosis off


	// ****************************************************************
	// Bus, register and init processes
	// ****************************************************************
	// Answer phase and read data capture
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r <= req & ~ack_r;
			if (avs_read & ~ack_r) begin
				rdata_r <= selSet ? {16'h0000, setup_r} :
					selVal ? {20'h00000, value_r} :
					selFlt ? {22'h000000, fault_r} :
					selSta ? {16'h0000, 4'h0, dataCode} : 32'h00000000;
			end
		end
	end

	// Software-written registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			setup_r <= `SDE_SETUP_RESET;
			value_r <= 12'h000;
			fault_r <= 10'h000;
		end else if (wrTake) begin
			if (selSet) setup_r <= setupNxt[15:0];
			if (selVal) value_r <= valueNxt[11:0];
			if (selFlt) fault_r <= faultNxt[9:0];
		end
	end

	// Unmapped writes are dropped


	// Power-up initialisation timer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			initCnt_r  <= 32'h00000000;
			initDone_r <= 1'b0;
		end else if (!initDone_r) begin
			initCnt_r  <= initCnt_r + 32'h00000001;
			initDone_r <= initCnt_r == 32'(INIT_CYC - 1);                 // [R17]
		end
	end

	// Code held at zero until init is done


	// ****************************************************************
	// Tick divider
	// ****************************************************************
	logic [15:0] tickCnt_r;  // Divider count
	wire tick = tickCnt_r == 16'(`SDE_TICK_CYC - 1);
	always_ff @(posedge clock) begin
		if (!rst_n) tickCnt_r <= 16'h0000;
		else tickCnt_r <= tick ? 16'h0000 : tickCnt_r + 16'h0001;     // [R3]
	end

	// Tick is a one-cycle enable pulse
	// Other clock rates change only the tick and init counts


	// ****************************************************************
	// CRC over data nibbles plus a zero nibble
	// ****************************************************************
	// Shift four times, then add the nibble
	// Zero nibble flushes the last data nibble
	function automatic logic [3:0] crcStep(input logic [3:0] c, input logic [3:0] d);
		logic [3:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = r[3] ? ((r << 1) ^ `SDE_CRC_POLY) : (r << 1);     // [R9]
		end
		return r ^ d;
	endfunction
	// Status nibble excluded; seed then d3,d2,d1, then zero
	wire [3:0] crcVal = crcStep(crcStep(crcStep(crcStep(`SDE_CRC_SEED,
		dataCode[11:8]), dataCode[7:4]), dataCode[3:0]), 4'h0);    // [R8] [R10]

	// ****************************************************************
	// SENT sequencer
	// ****************************************************************
	sde_state_t  st_r;        // Sequencer state
	logic [7:0]  perCnt_r;    // Ticks in current period
	logic [7:0]  perLen_r;    // Length of current period
	logic [15:0] frameCnt_r;  // Ticks since telegram start
	logic [1:0]  nibIdx_r;    // Data nibble index
	logic [11:0] txData_r;    // Data latched per telegram
	logic [3:0]  txCrc_r;     // CRC latched per telegram
	logic        sentLine_r;  // SENT line level
	wire sentMode = setup_r[`SDE_B_FMT];                                // [R23]
	wire perEnd   = tick & (perCnt_r == perLen_r - 8'h01);

	// Periods run fall to fall
	// Each period opens with a low pulse
	// Data and CRC latched at the sync edge
	// Mid-frame writes go out next frame
	// Leaving SENT mode aborts, line high
	// Frame must outlast longest telegram


	always_ff @(posedge clock) begin
		if (!rst_n || !sentMode) begin
			st_r       <= SDE_IDLE;
			perCnt_r   <= 8'h00;
			perLen_r   <= `SDE_SYNC_TICKS;
			frameCnt_r <= 16'h0000;
			nibIdx_r   <= 2'd0;
			txData_r   <= 12'h000;
			txCrc_r    <= 4'h0;
			sentLine_r <= 1'b1;                                          // [R4]
		end else if (tick) begin
			frameCnt_r <= frameCnt_r + 16'h0001;
			perCnt_r   <= perEnd ? 8'h00 : perCnt_r + 8'h01;
			// Low for the first ticks of every period, then high
			sentLine_r <= (st_r == SDE_IDLE || st_r == SDE_PAUSE) ? 1'b1 :
				((perEnd ? 8'h00 : perCnt_r + 8'h01) >= `SDE_NLOW_TICKS) | perEnd;  // [R5]
			case (st_r)
				SDE_IDLE: begin
					if (initDone_r) begin                                      // [R17]
						st_r       <= SDE_SYNC;
						perLen_r   <= `SDE_SYNC_TICKS;                           // [R6]
						perCnt_r   <= 8'h00;
						frameCnt_r <= 16'h0000;
						txData_r   <= dataCode;
						txCrc_r    <= crcVal;
						sentLine_r <= 1'b0;                                      // [R1]
					end
				end
				SDE_SYNC: if (perEnd) begin
					st_r       <= SDE_STAT;                                   // [R2]
					perLen_r   <= `SDE_NIB_BASE;                              // [R12]
					sentLine_r <= 1'b0;
				end
				SDE_STAT: if (perEnd) begin
					st_r       <= SDE_DATA;
					nibIdx_r   <= 2'd0;
					perLen_r   <= `SDE_NIB_BASE + {4'h0, txData_r[11:8]};     // [R6] [R11]
					sentLine_r <= 1'b0;
				end
				SDE_DATA: if (perEnd) begin
					sentLine_r <= 1'b0;
					if (nibIdx_r == 2'd2) begin
						st_r     <= SDE_CRC;
						perLen_r <= `SDE_NIB_BASE + {4'h0, txCrc_r};
					end else begin
						nibIdx_r <= nibIdx_r + 2'd1;
						perLen_r <= `SDE_NIB_BASE + {4'h0, (nibIdx_r == 2'd0) ?
							txData_r[7:4] : txData_r[3:0]};
					end
				end
				SDE_CRC: if (perEnd) begin
					st_r       <= SDE_PAUSE;                                  // [R7]
					sentLine_r <= 1'b0;
					perLen_r   <= 8'hff;
				end
				SDE_PAUSE: begin
					// Pause pulse low, then high up to the frame edge
					if (frameCnt_r == `SDE_FRAME_TICKS - 16'h0001) begin
						st_r       <= SDE_SYNC;
						perLen_r   <= `SDE_SYNC_TICKS;
						perCnt_r   <= 8'h00;
						frameCnt_r <= 16'h0000;
						txData_r   <= dataCode;
						txCrc_r    <= crcVal;
						sentLine_r <= 1'b0;                                      // [R1]
					end else begin
						// Sticky high: pause outlasts counter wrap
						sentLine_r <= sentLine_r | (perCnt_r + 8'h01 >= `SDE_NLOW_TICKS);
					end
				end
				default: st_r <= SDE_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// PWM generator
	// ****************************************************************
	logic [31:0] pwmCnt_r;   // Position in PWM period
	logic        pwmLine_r;  // PWM line level
	wire [1:0] freqSel = setup_r[`SDE_B_FREQ_LO +: 2];
	wire [31:0] basePer = (freqSel == 2'd0) ? `SDE_PWM_1K :
		(freqSel == 2'd1) ? `SDE_PWM_500 :
		(freqSel == 2'd2) ? `SDE_PWM_200 : `SDE_PWM_2K;
	wire pwmFail = devErr | pathEr;
	wire [31:0] period = pwmFail ? {basePer[30:0], 1'b0} : basePer;   // [R18]
	// Fault duty in 1/1000 steps; normal duty follows dataCode
	wire [9:0] dutyMil =
		(flt.selfTest & diagOn) ? 10'd950 :                              // [R19]
		(flt.overV & diagOn)    ? 10'd750 :                              // [R20]
		(flt.fieldLo & diagOn)  ? 10'd625 :
		(flt.fieldHi & diagOn)  ? 10'd550 : 10'd700;
	wire [43:0] highFault = 44'(period) * 44'(dutyMil) / 44'd1000;
	wire [43:0] highNorm  = 44'(period) * 44'(dataCode) / 44'd4096;
	wire [31:0] highCyc   = pwmFail ? highFault[31:0] : highNorm[31:0];

	// Period follows faults at once; a fault
	// may stretch or cut the running period
	// Normal duty is code over 4096
	// Undervoltage bypasses this path


	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pwmCnt_r  <= 32'h00000000;
			pwmLine_r <= 1'b1;
		end else begin
			pwmCnt_r  <= (pwmCnt_r >= period - 32'h00000001) ? 32'h00000000 :
				pwmCnt_r + 32'h00000001;
			pwmLine_r <= pwmCnt_r < highCyc;
		end
	end

	// ****************************************************************
	// Output selection
	// ****************************************************************
	wire uvHold = diagOn & flt.underV;
	assign lineOut = sentMode ? sentLine_r :
		uvHold ? ~bandLow : pwmLine_r;                                   // [R21]
	assign errorBand    = anyErr;                                        // [R22]
	assign errorBandLow = bandLow;

	// Band is any unmasked device, path or undervoltage fault; clamps do not raise it
	// Low side honoured only when locked
endmodule

`default_nettype wire

// >>> logic/sde_pkg.sv
/*
 * Types of the single-wire output encoder.
 * Assumes the defines header is compiled alongside.
 */
`default_nettype none
package sde_pkg;
	// Telegram sequencer states, Gray from idle through pause; pause to sync flips two bits
	typedef enum logic [2:0] {
		SDE_IDLE  = 3'b000,
		SDE_SYNC  = 3'b001,
		SDE_STAT  = 3'b011,
		SDE_DATA  = 3'b010,
		SDE_CRC   = 3'b110,
		SDE_PAUSE = 3'b111
	} sde_state_t;

	// Decoded diagnostic state
	typedef struct packed {
		logic selfTest;
		logic overV;
		logic underV;
		logic fieldHi;
		logic fieldLo;
		logic pathErr;
		logic clampHi;
		logic clampLo;
		logic init;
	} sde_fault_t;
endpackage
`default_nettype wire

// >>> tb/sde_ecu_model.sv
/* Receiving controller: decodes one SENT telegram from the line.
   Assumes the line is high when armed; it drives nothing back. */
`include "sde_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sde_ecu_model (
	input  wire logic        clock,     // System clock
	input  wire logic        rst_n,     // Sync reset
	input  wire logic        lineOut,   // Line from the sensor
	input  wire logic        arm,       // Start listening
	output var  logic        frameDone, // Pulse after CRC period
	output var  logic        lowOk,     // Lows from sync to CRC had nominal width
	output var  logic        syncOk,    // Sync period nominal
	output var  logic        tickOk,    // Periods whole ticks
	output logic      [3:0]  statNib,   // Status nibble
	output logic      [11:0] dataCode,  // Three data nibbles
	output logic      [3:0]  crcNib     // Checksum nibble
);
	// ************************************************
	// Edge timing and field capture
	// ************************************************
	localparam int TICK = `SDE_TICK_CYC;	// Cycles per tick
	logic       prevR;	// Line one cycle ago
	int         perR, lowR, idxR;	// Period, low length, falls seen
	logic [3:0] nibR [0:4];	// Status, data, CRC
	wire        fallW = prevR & ~lineOut;	// Falling edge
	wire        riseW = ~prevR & lineOut;	// Rising edge
	assign statNib  = nibR[0];
	assign dataCode = {nibR[1], nibR[2], nibR[3]};	// First data nibble is most significant
	assign crcNib   = nibR[4];

	// Periods measured fall to fall, fields in telegram order
	always_ff @(posedge clock) begin
		frameDone <= 1'b0;
		prevR     <= lineOut;
		perR      <= fallW ? 1 : perR + 1;
		lowR      <= fallW ? 1 : lowR + 1;
		if (!rst_n || !arm) begin
			prevR  <= 1'b1;
			idxR   <= 0;
			{lowOk, syncOk, tickOk} <= 3'h5;
		end else begin
			if (riseW && idxR inside {[1:6]} && lowR != `SDE_NLOW_TICKS * TICK) begin
				lowOk <= 1'b0;
			end
			if (fallW && idxR < 7) begin
				idxR <= idxR + 1;
				if (idxR >= 1 && perR % TICK != 0) begin
					tickOk <= 1'b0;
				end
				if (idxR == 1) begin
					syncOk <= (perR == `SDE_SYNC_TICKS * TICK);
				end
				if (idxR >= 2) begin
					nibR[idxR-2] <= 4'(perR / TICK - `SDE_NIB_BASE);
				end
				if (idxR == 6) begin
					frameDone <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/sde_encoder_checker.sv
/* Port checker of the output encoder.
   Assumes it is bound into sde_encoder and sees one clock. */
`include "sde_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sde_encoder_checker #(
	parameter int INIT_CYC = 100	// Init time, cycles
) (
	input wire logic        clock,           // System clock
	input wire logic        rst_n,           // Sync reset
	input wire logic [3:0]  avs_address,     // Byte address
	input wire logic        avs_read,        // Read request
	input wire logic        avs_write,       // Write request
	input wire logic [31:0] avs_writedata,   // Write data
	input wire logic [3:0]  avs_byteenable,  // Byte lanes
	input wire logic [31:0] avs_readdata,    // Read data
	input wire logic        avs_waitrequest, // Stall
	input wire logic        lineOut,         // Line level
	input wire logic        errorBand,       // Band active
	input wire logic        errorBandLow     // Band low side
);
	// ************************************************
	// Setup mirrors and line counters
	// ************************************************
	localparam int TICK = `SDE_TICK_CYC;	// Cycles per tick
	logic prevR, sentR, armR, lockR, offR, bandR;	// Mirrors
	int   perR, lowR, upR;	// Period, low and uptime counts
	wire  fallW = prevR & ~lineOut;	// Falling edge
	wire  riseW = ~prevR & lineOut;	// Rising edge
	wire  takeW = avs_write & ~avs_waitrequest & (avs_address == 4'h0);	// Setup write

	// Edge counters run freely, uptime saturates at INIT_CYC; mirrors follow writes that take effect
	always_ff @(posedge clock) begin
		prevR <= lineOut;
		perR  <= fallW ? 1 : perR + 1;
		lowR  <= fallW ? 1 : lowR + 1;
		upR   <= (upR < INIT_CYC) ? upR + 1 : upR;
		if (fallW && sentR) begin
			armR <= 1'b1;	// Only periods after a SENT fall are judged
		end
		if (takeW && avs_byteenable[0]) begin
			{bandR, offR, lockR} <= {avs_writedata[7], avs_writedata[1:0]};
		end
		if (takeW && avs_byteenable[1]) begin
			sentR <= avs_writedata[12];
		end
		if (!rst_n) begin
			prevR <= 1'b1;
			{sentR, armR, lockR, offR, bandR} <= 5'h00;
			upR   <= 0;
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	wait_once_a: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("wait state count wrong");
	idle_nowait_a: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
		else $error("stall without request");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
		|-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	idle_high_a: assert property ($rose(rst_n) |-> lineOut)
		else $error("line not high after reset");
	init_quiet_a: assert property (sentR && upR < INIT_CYC |-> lineOut)
		else $error("telegram before init time");
	low_width_a: assert property (armR && sentR && riseW |-> lowR == 5 * TICK)
		else $error("low pulse length wrong");
	tick_whole_a: assert property (armR && sentR && fallW |-> perR % TICK == 0)
		else $error("period not whole ticks");
	band_side_a: assert property (errorBandLow == (lockR & bandR))
		else $error("band side wrong");
	diag_mask_a: assert property (offR |-> !errorBand)
		else $error("masked fault reached band");

	cover property (armR && sentR && fallW);
	cover property (errorBandLow && errorBand);
	cover property (avs_read && !avs_waitrequest && avs_address == 4'h1);
endmodule

bind sde_encoder sde_encoder_checker #(.INIT_CYC(INIT_CYC)) i_sde_encoder_checker (
	.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lineOut(lineOut),
	.errorBand(errorBand), .errorBandLow(errorBandLow));
`default_nettype wire

// >>> tb/sde_encoder_tb.sv
/* Testbench of the output encoder: bus tasks, one decoded telegram,
   code table, band and hold checks. Assumes the bound checker. */
`include "sde_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sde_encoder_tb;
	// ************************************************
	// Signals and instances
	// ************************************************
	logic        clock, rst_n, avs_read, avs_write, arm;	// Drives
	logic [3:0]  avs_address, avs_byteenable;	// Address, lanes
	logic [31:0] avs_writedata, avs_readdata, rd;	// Data
	logic        avs_waitrequest, lineOut, errorBand, errorBandLow;	// Outputs
	logic        frameDone, lowOk, syncOk, tickOk;	// Receiver flags
	logic [3:0]  statNib, crcNib;	// Received nibbles
	logic [11:0] dataCode;	// Received data
	int          bad_count, check_count;	// Tallies
	logic [9:0]  fTab [11] = '{10'h001, 10'h002, 10'h008, 10'h010, 10'h020, 10'h040,
		10'h080, 10'h100, 10'h200, 10'h0a1, 10'h000};	// Fault patterns
	logic [11:0] cTab [11] = '{12'hffb, 12'hffb, 12'hffa, 12'hffa, 12'hffa, 12'hffa,
		12'hff8, 12'h001, 12'h000, 12'hffb, 12'h102};	// Codes expected

	sde_encoder #(.INIT_CYC(100)) i_sde_encoder (.clock(clock), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lineOut(lineOut),
		.errorBand(errorBand), .errorBandLow(errorBandLow));
	sde_ecu_model i_sde_ecu_model (.clock(clock), .rst_n(rst_n), .lineOut(lineOut),
		.arm(arm), .frameDone(frameDone), .lowOk(lowOk), .syncOk(syncOk), .tickOk(tickOk),
		.statNib(statNib), .dataCode(dataCode), .crcNib(crcNib));

	// ************************************************
	// Bus, compare and closing tasks
	// ************************************************
	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Own checksum: seed, four-bit shift step per nibble, then one zero nibble
	function automatic logic [3:0] sent_crc(input logic [11:0] v);
		logic [3:0] c;
		c = `SDE_CRC_SEED;
		for (int i = 3; i >= 0; i--) begin
			for (int b = 0; b < 4; b++) begin
				c = c[3] ? ((c << 1) ^ `SDE_CRC_POLY) : (c << 1);
			end
			c = c ^ ((i == 0) ? 4'h0 : v[4*i-1 -: 4]);
		end
		return c;
	endfunction

	// ************************************************
	// Clock, watchdog and test sequence
	// ************************************************
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// A full telegram is near 77k cycles; this leaves ample margin
	initial begin
		repeat (99000) @(posedge clock);
		bad_count++;
		give_verdict();
	end

	initial begin
		{rst_n, avs_read, avs_write, arm} = 4'h0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		bad_count = 0;
		check_count = 0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		bus(1'b1, 4'h4, 32'h102);
		rdc(4'hc, 32'h0);
		bus(1'b1, 4'h0, 32'h1000);
		rdc(4'h0, 32'h1000);
		rdc(4'h1, 32'h0);
		@(posedge clock);
		arm <= 1'b1;
		while (frameDone !== 1'b1) begin
			@(posedge clock);
		end
		cmp(statNib, 32'h0);
		cmp(dataCode, 32'h102);
		cmp(crcNib, sent_crc(12'h102));
		cmp({lowOk, syncOk, tickOk}, 32'h7);
		for (int i = 0; i < 11; i++) begin
			bus(1'b1, 4'h8, {22'h0, fTab[i]});
			rdc(4'hc, cTab[i]);
		end
		bus(1'b1, 4'h4, 32'hfff);
		rdc(4'hc, 32'hff7);
		bus(1'b1, 4'h4, 32'h0);
		rdc(4'hc, 32'h002);
		bus(1'b1, 4'h8, 32'h001);
		bus(1'b1, 4'h0, 32'h1080);
		@(posedge clock);
		cmp({errorBand, errorBandLow}, 32'h2);
		bus(1'b1, 4'h0, 32'h1081);
		@(posedge clock);
		cmp({errorBand, errorBandLow}, 32'h3);
		bus(1'b1, 4'h0, 32'h1083);
		@(posedge clock);
		cmp(errorBand, 32'h0);
		bus(1'b1, 4'h0, 32'h0000);
		bus(1'b1, 4'h8, 32'h004);
		repeat (40) @(posedge clock);
		cmp(lineOut, 32'h1);
		bus(1'b1, 4'h0, 32'h0081);
		repeat (40) @(posedge clock);
		cmp(lineOut, 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
